// ---- wave_timer_pkg.sv ----
// constants shared by the waveform timer and its output units
// assumes an 8-bit register port and a 16-bit counter
package wave_timer_pkg;
  localparam int unsigned addr_width = 8;
  localparam int unsigned data_width = 8;
  localparam int unsigned count_width = 16;
  localparam int unsigned chan_count = 2;
  localparam int unsigned chan_a = 0;
  localparam int unsigned chan_b = 1;

  // register byte addresses
  localparam logic [7:0] addr_status = 8'h36;
  localparam logic [7:0] addr_control_a = 8'h80;
  localparam logic [7:0] addr_control_b = 8'h81;
  localparam logic [7:0] addr_count_lo = 8'h84;
  localparam logic [7:0] addr_count_hi = 8'h85;
  localparam logic [7:0] addr_capture_lo = 8'h86;
  localparam logic [7:0] addr_capture_hi = 8'h87;
  localparam logic [7:0] addr_compare_a_lo = 8'h88;
  localparam logic [7:0] addr_compare_a_hi = 8'h89;
  localparam logic [7:0] addr_compare_b_lo = 8'h8a;
  localparam logic [7:0] addr_compare_b_hi = 8'h8b;

  // field positions
  localparam int unsigned pos_action_a = 6;
  localparam int unsigned pos_action_b = 4;
  localparam int unsigned pos_mode_low = 0;
  localparam int unsigned pos_mode_high = 3;
  localparam int unsigned pos_overflow = 0;

  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [15:0] reset_word = 16'h0000;
  localparam logic [1:0] action_off = 2'h0;
  localparam logic [1:0] action_toggle = 2'h1;

  // counter limits
  localparam logic [15:0] count_bottom = 16'h0000;
  localparam logic [15:0] count_max = 16'hffff;
  localparam logic [15:0] top_8bit = 16'h00ff;
  localparam logic [15:0] top_9bit = 16'h01ff;
  localparam logic [15:0] top_10bit = 16'h03ff;
  localparam logic [15:0] count_step = 16'h0001;

  // waveform modes
  localparam logic [3:0] mode_normal = 4'h0;
  localparam logic [3:0] mode_pc_8 = 4'h1;
  localparam logic [3:0] mode_pc_9 = 4'h2;
  localparam logic [3:0] mode_pc_10 = 4'h3;
  localparam logic [3:0] mode_ctc_cmp = 4'h4;
  localparam logic [3:0] mode_fast_8 = 4'h5;
  localparam logic [3:0] mode_fast_9 = 4'h6;
  localparam logic [3:0] mode_fast_10 = 4'h7;
  localparam logic [3:0] mode_pfc_cap = 4'h8;
  localparam logic [3:0] mode_pfc_cmp = 4'h9;
  localparam logic [3:0] mode_pc_cap = 4'ha;
  localparam logic [3:0] mode_pc_cmp = 4'hb;
  localparam logic [3:0] mode_ctc_cap = 4'hc;
  localparam logic [3:0] mode_reserved = 4'hd;
  localparam logic [3:0] mode_fast_cap = 4'he;
  localparam logic [3:0] mode_fast_cmp = 4'hf;

  typedef enum logic [1:0] {
    class_nonpwm,
    class_fast,
    class_dual
  } mode_class_type;

  typedef enum logic [1:0] {
    update_now,
    update_top,
    update_bottom
  } update_point_type;
endpackage

// ---- wave_output_unit.sv ----
// one compare channel's waveform output register
// assumes match and top/bottom strobes qualified by the timer tick
`timescale 1ns/1ps
`default_nettype none
module wave_output_unit
  import wave_timer_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic [1:0] action_i,
  input wire mode_class_type mode_class_i,
  input wire logic toggle_allowed_i,
  input wire logic match_i,
  input wire logic at_top_i,
  input wire logic counting_down_i,
  input wire logic cmp_eq_top_i,
  input wire logic cmp_eq_bottom_i,
  output logic wave_o
);

  logic next_wave;

  always_comb begin
    next_wave = wave_o;
    case (mode_class_i)
      class_nonpwm: begin
        if (match_i) begin
          case (action_i)
            2'h1: next_wave = ~wave_o;
            2'h2: next_wave = 1'b0;
            2'h3: next_wave = 1'b1;
            default: next_wave = wave_o;
          endcase
        end
      end
      class_fast: begin
        if (action_i == action_toggle) begin
          if (toggle_allowed_i && match_i) begin
            next_wave = ~wave_o;
          end
        end else if (action_i[1]) begin
          if (at_top_i) begin
            next_wave = ~action_i[0];
          end else if (match_i && !cmp_eq_top_i) begin
            next_wave = action_i[0];
          end
        end
      end
      class_dual: begin
        if (action_i == action_toggle) begin
          if (toggle_allowed_i && match_i) begin
            next_wave = ~wave_o;
          end
        end else if (action_i[1]) begin
          if (cmp_eq_bottom_i) begin
            next_wave = action_i[0];
          end else if (cmp_eq_top_i) begin
            next_wave = ~action_i[0];
          end else if (match_i) begin
            next_wave = counting_down_i ? ~action_i[0] : action_i[0];
          end
        end
      end
      default: next_wave = wave_o;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wave_o <= 1'b0;
    end else if (ce_i && tick_i) begin
      wave_o <= next_wave;
    end
  end

endmodule // wave_output_unit
`default_nettype wire

// ---- timer16_waveform_mode_control.sv ----
// 16-bit timer waveform generation: mode decode, counter, compare buffers, pin override
// assumes synchronous inputs, tick_i as prescaled count enable, plain 8-bit register port
//
// Operation
// - any set bit in channel A action field hands its pin to wave output A, except code 01 in PWM modes 1 to 3 and 5 to 7
// - any set bit in channel B action field hands its pin to wave output B, except code 01 in any PWM mode
// - pin driver enabled only while the pin direction bit selects output
// - non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM code 01 toggles A only in modes 14, 15; B disconnected
// - fast PWM code 10 clears on match sets at top; 11 opposite
// - fast PWM: compare equal top with upper bit set ignores match, keeps top action
// - dual-slope code 01 toggles A only in modes 8 to 11; B disconnected
// - dual-slope code 10 clears on up match, sets on down match; 11 reverse
// - mode formed from low bits 1:0 here and high bits in control B
// - normal, clear-on-match and three PWM kinds; mode 13 reserved
// - modes 0, 4, 12 update compares at once, overflow at maximum
// - phase correct fixed or register tops, update at top, overflow at bottom
// - fast PWM fixed or register tops, update and overflow at top
// - modes 8, 9: top from capture or compare A, update and overflow at bottom
// - high mode bits sit at bits 4:3 of control B
// - dual-slope compare at bottom holds low, at top holds high; inverted opposite
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer16_waveform_mode_control
  import wave_timer_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic [addr_width-1:0] addr_i,
  input wire logic [data_width-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [data_width-1:0] rdata_o,
  input wire logic dir_a_i,
  input wire logic dir_b_i,
  input wire logic port_a_i,
  input wire logic port_b_i,
  output logic pin_a_o,
  output logic pin_a_oe_o,
  output logic pin_b_o,
  output logic pin_b_oe_o,
  output logic wave_out_a_o,
  output logic wave_out_b_o,
  output logic overflow_flag_o
);

  logic [7:0] waveform_control_a;
  logic [1:0] wave_mode_high;
  logic [count_width-1:0] count_value;
  logic [count_width-1:0] capture_value;
  logic [count_width-1:0] cmp_buf [chan_count];
  logic [count_width-1:0] cmp_act [chan_count];
  logic counting_down;
  logic block_match;
  logic overflow_flag;

  logic [3:0] wave_mode_sel;
  logic [1:0] chan_a_output_action;
  logic [1:0] chan_b_output_action;
  logic [1:0] action [chan_count];
  logic [count_width-1:0] top_value;
  mode_class_type mode_class;
  update_point_type update_point;
  logic pfc_mode;
  logic toggle_ok;
  logic step;
  logic at_top;
  logic at_bottom;
  logic at_max;
  logic overflow_event;
  logic buffer_load;
  logic [count_width-1:0] next_count;
  logic next_down;
  logic [chan_count-1:0] wave;
  logic [chan_count-1:0] connect;
  logic [chan_count-1:0] dir;
  logic [chan_count-1:0] port_val;
  logic [chan_count-1:0] pin_q;
  logic [chan_count-1:0] oe_q;
  logic wr_status;

  assign wave_mode_sel = {wave_mode_high, waveform_control_a[pos_mode_low +: 2]};
  assign chan_a_output_action = waveform_control_a[pos_action_a +: 2];
  assign chan_b_output_action = waveform_control_a[pos_action_b +: 2];
  assign action[chan_a] = chan_a_output_action;
  assign action[chan_b] = chan_b_output_action;
  assign step = ce_i && tick_i;
  assign dir = {dir_b_i, dir_a_i};
  assign port_val = {port_b_i, port_a_i};

  // mode decode: top source, waveform class, compare update point
  always_comb begin
    top_value = count_max;
    mode_class = class_nonpwm;
    update_point = update_now;
    pfc_mode = 1'b0;
    toggle_ok = 1'b0;
    case (wave_mode_sel)
      mode_normal: begin
        top_value = count_max;
      end
      mode_ctc_cmp: begin
        top_value = cmp_act[chan_a];
      end
      mode_ctc_cap: begin
        top_value = capture_value;
      end
      mode_pc_8, mode_pc_9, mode_pc_10, mode_pc_cap, mode_pc_cmp: begin
        mode_class = class_dual;
        update_point = update_top;
        case (wave_mode_sel)
          mode_pc_8: top_value = top_8bit;
          mode_pc_9: top_value = top_9bit;
          mode_pc_10: top_value = top_10bit;
          mode_pc_cap: top_value = capture_value;
          default: top_value = cmp_act[chan_a];
        endcase
        toggle_ok = (wave_mode_sel == mode_pc_cap) || (wave_mode_sel == mode_pc_cmp);
      end
      mode_pfc_cap, mode_pfc_cmp: begin
        mode_class = class_dual;
        update_point = update_bottom;
        pfc_mode = 1'b1;
        toggle_ok = 1'b1;
        top_value = (wave_mode_sel == mode_pfc_cap) ? capture_value : cmp_act[chan_a];
      end
      mode_fast_8, mode_fast_9, mode_fast_10, mode_fast_cap, mode_fast_cmp: begin
        mode_class = class_fast;
        update_point = update_top;
        case (wave_mode_sel)
          mode_fast_8: top_value = top_8bit;
          mode_fast_9: top_value = top_9bit;
          mode_fast_10: top_value = top_10bit;
          mode_fast_cap: top_value = capture_value;
          default: top_value = cmp_act[chan_a];
        endcase
        toggle_ok = (wave_mode_sel == mode_fast_cap) || (wave_mode_sel == mode_fast_cmp);
      end
      mode_reserved: begin
        top_value = count_max;
      end
      default: begin
        top_value = count_max;
      end
    endcase
  end

  assign at_top = (count_value == top_value);
  assign at_bottom = (count_value == count_bottom);
  assign at_max = (count_value == count_max);

  // overflow points per mode class, buffer load points per update point
  always_comb begin
    case (mode_class)
      class_fast: overflow_event = at_top;
      class_dual: overflow_event = at_bottom && counting_down;
      default: overflow_event = at_max;
    endcase
    case (update_point)
      update_top: buffer_load = at_top;
      update_bottom: buffer_load = at_bottom && counting_down;
      default: buffer_load = 1'b1;
    endcase
  end

  // counting sequence
  always_comb begin
    next_count = count_value;
    next_down = counting_down;
    if (mode_class == class_dual) begin
      if (!counting_down) begin
        if (at_top) begin
          next_down = 1'b1;
          next_count = count_value - count_step;
        end else begin
          next_count = count_value + count_step;
        end
      end else begin
        if (at_bottom) begin
          next_down = 1'b0;
          next_count = count_value + count_step;
        end else begin
          next_count = count_value - count_step;
        end
      end
    end else begin
      next_down = 1'b0;
      next_count = at_top ? count_bottom : count_value + count_step;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_value <= reset_word;
      counting_down <= 1'b0;
      block_match <= 1'b0;
    end else if (ce_i) begin
      if (wr_i && addr_i == addr_count_lo) begin
        count_value[7:0] <= wdata_i;
        block_match <= 1'b1;
      end else if (wr_i && addr_i == addr_count_hi) begin
        count_value[15:8] <= wdata_i;
        block_match <= 1'b1;
      end else if (tick_i) begin
        count_value <= next_count;
        counting_down <= next_down;
        block_match <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      waveform_control_a <= reset_byte;
      wave_mode_high <= 2'h0;
    end else if (ce_i && wr_i) begin
      if (addr_i == addr_control_a) begin
        waveform_control_a <= {wdata_i[7:4], 2'h0, wdata_i[1:0]};
      end
      if (addr_i == addr_control_b) begin
        wave_mode_high <= wdata_i[pos_mode_high +: 2];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      capture_value <= reset_word;
    end else if (ce_i && wr_i) begin
      if (addr_i == addr_capture_lo) begin
        capture_value[7:0] <= wdata_i;
      end
      if (addr_i == addr_capture_hi) begin
        capture_value[15:8] <= wdata_i;
      end
    end
  end

  // overflow flag: write one clears, a set in the same cycle wins
  assign wr_status = ce_i && wr_i && (addr_i == addr_status) && wdata_i[pos_overflow];

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overflow_flag <= 1'b0;
    end else if (ce_i) begin
      if (step && overflow_event) begin
        overflow_flag <= 1'b1;
      end else if (wr_status) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // per-channel compare buffers, output units and pin override
  genvar ch;
  generate
    for (ch = 0; ch < chan_count; ch++) begin : g_chan
      localparam logic [7:0] addr_lo = (ch == chan_a) ? addr_compare_a_lo : addr_compare_b_lo;
      localparam logic [7:0] addr_hi = (ch == chan_a) ? addr_compare_a_hi : addr_compare_b_hi;
      logic match;
      logic tog;

      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cmp_buf[ch] <= reset_word;
        end else if (ce_i && wr_i) begin
          if (addr_i == addr_lo) begin
            cmp_buf[ch][7:0] <= wdata_i;
          end
          if (addr_i == addr_hi) begin
            cmp_buf[ch][15:8] <= wdata_i;
          end
        end
      end

      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cmp_act[ch] <= reset_word;
        end else if (ce_i) begin
          if (update_point == update_now) begin
            cmp_act[ch] <= cmp_buf[ch];
          end else if (tick_i && buffer_load) begin
            cmp_act[ch] <= cmp_buf[ch];
          end
        end
      end

      assign match = (count_value == cmp_act[ch]) && !block_match;
      assign tog = toggle_ok && (ch == chan_a);

      wave_output_unit u_out (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .tick_i(tick_i),
        .action_i(action[ch]),
        .mode_class_i(mode_class),
        .toggle_allowed_i(tog),
        .match_i(match),
        .at_top_i(at_top),
        .counting_down_i(counting_down),
        .cmp_eq_top_i(cmp_act[ch] == top_value),
        .cmp_eq_bottom_i(cmp_act[ch] == count_bottom),
        .wave_o(wave[ch])
      );

      // code 01 outside its toggle modes leaves the pin to the port
      assign connect[ch] = (action[ch] != action_off) &&
                           !(mode_class != class_nonpwm && action[ch] == action_toggle && !tog);

      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pin_q[ch] <= 1'b0;
          oe_q[ch] <= 1'b0;
        end else if (ce_i) begin
          pin_q[ch] <= connect[ch] ? wave[ch] : port_val[ch];
          oe_q[ch] <= dir[ch];
        end
      end
    end
  endgenerate

  assign pin_a_o = pin_q[chan_a];
  assign pin_b_o = pin_q[chan_b];
  assign pin_a_oe_o = oe_q[chan_a];
  assign pin_b_oe_o = oe_q[chan_b];
  assign wave_out_a_o = wave[chan_a];
  assign wave_out_b_o = wave[chan_b];
  assign overflow_flag_o = overflow_flag;

  // read port, data one cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= reset_byte;
    end else if (ce_i) begin
      rdata_o <= reset_byte;
      if (rd_i) begin
        case (addr_i)
          addr_status: rdata_o <= {7'h00, overflow_flag};
          addr_control_a: rdata_o <= waveform_control_a;
          addr_control_b: rdata_o <= {3'h0, wave_mode_high, 3'h0};
          addr_count_lo: rdata_o <= count_value[7:0];
          addr_count_hi: rdata_o <= count_value[15:8];
          addr_capture_lo: rdata_o <= capture_value[7:0];
          addr_capture_hi: rdata_o <= capture_value[15:8];
          addr_compare_a_lo: rdata_o <= cmp_buf[chan_a][7:0];
          addr_compare_a_hi: rdata_o <= cmp_buf[chan_a][15:8];
          addr_compare_b_lo: rdata_o <= cmp_buf[chan_b][7:0];
          addr_compare_b_hi: rdata_o <= cmp_buf[chan_b][15:8];
          default: rdata_o <= reset_byte;
        endcase
      end
    end
  end

endmodule // timer16_waveform_mode_control
`default_nettype wire

// ---- timer16_waveform_mode_control_properties.sv ----
// port checker for the waveform timer
// assumes bind onto the timer top module, single clock domain
`timescale 1ns/1ps
`default_nettype none
module timer16_waveform_mode_control_properties
  import wave_timer_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic [addr_width-1:0] addr_i,
  input wire logic [data_width-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [data_width-1:0] rdata_o,
  input wire logic dir_a_i,
  input wire logic dir_b_i,
  input wire logic port_a_i,
  input wire logic port_b_i,
  input wire logic pin_a_o,
  input wire logic pin_a_oe_o,
  input wire logic pin_b_o,
  input wire logic pin_b_oe_o,
  input wire logic wave_out_a_o,
  input wire logic wave_out_b_o,
  input wire logic overflow_flag_o
);
  default clocking dcb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  AST_OE_A: assert property (ce_i |=> pin_a_oe_o == $past(dir_a_i))
    else $error("pin a enable does not follow direction");
  AST_OE_B: assert property (ce_i |=> pin_b_oe_o == $past(dir_b_i))
    else $error("pin b enable does not follow direction");
  AST_PIN_A: assert property (ce_i |=> (pin_a_o == $past(wave_out_a_o)) || (pin_a_o == $past(port_a_i)))
    else $error("pin a neither wave nor port");
  AST_PIN_B: assert property (ce_i |=> (pin_b_o == $past(wave_out_b_o)) || (pin_b_o == $past(port_b_i)))
    else $error("pin b neither wave nor port");
  AST_RSVD_A: assert property (ce_i && rd_i && addr_i == addr_control_a |=> rdata_o[3:2] == 2'h0)
    else $error("control a reserved bits not zero");
  AST_HIGH_B: assert property (ce_i && rd_i && addr_i == addr_control_b |=> (rdata_o & 8'he7) == 8'h00)
    else $error("control b unused bits not zero");
  AST_READBACK: assert property ((ce_i && wr_i && addr_i == addr_control_a) ##1
    (ce_i && rd_i && addr_i == addr_control_a) |=> rdata_o == ($past(wdata_i, 2) & 8'hf3))
    else $error("control a readback wrong");
  AST_OVF_HOLD: assert property (overflow_flag_o && !(wr_i && addr_i == addr_status) |=> overflow_flag_o)
    else $error("overflow flag dropped without clear");
  AST_OVF_CLR: assert property (ce_i && wr_i && addr_i == addr_status && wdata_i[0] && !tick_i
    |=> !overflow_flag_o)
    else $error("overflow flag not cleared");
  AST_OVF_CAUSE: assert property ($rose(overflow_flag_o) |-> $past(ce_i && tick_i))
    else $error("overflow set without tick");
  AST_WAVE_HOLD: assert property (!(ce_i && tick_i) |=> $stable(wave_out_a_o) && $stable(wave_out_b_o))
    else $error("wave output moved without tick");
endmodule // timer16_waveform_mode_control_properties

bind timer16_waveform_mode_control timer16_waveform_mode_control_properties u_props (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .tick_i(tick_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dir_a_i(dir_a_i),
  .dir_b_i(dir_b_i), .port_a_i(port_a_i), .port_b_i(port_b_i), .pin_a_o(pin_a_o),
  .pin_a_oe_o(pin_a_oe_o), .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe_o),
  .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o),
  .overflow_flag_o(overflow_flag_o)
);
`default_nettype wire

// ---- timer16_waveform_mode_control_test.sv ----
// self-checking bench for the waveform timer
// assumes package and bound checker compiled first
`timescale 1ns/1ps
`default_nettype none
module timer16_waveform_mode_control_test;
  import wave_timer_pkg::*;
  logic ref_clk_i, nrst_i, ce_i, tick_i, wr_i, rd_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic dir_a_i, dir_b_i, port_a_i, port_b_i, pin_a_o, pin_a_oe_o, pin_b_o, pin_b_oe_o;
  logic wave_out_a_o, wave_out_b_o, overflow_flag_o, ea, eb;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [1:0] ca [4] = '{2'h1, 2'h1, 2'h3, 2'h2};
  logic [1:0] cb [4] = '{2'h3, 2'h1, 2'h2, 2'h1};

  timer16_waveform_mode_control u_timer16_waveform_mode_control (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .tick_i(tick_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dir_a_i(dir_a_i),
    .dir_b_i(dir_b_i), .port_a_i(port_a_i), .port_b_i(port_b_i), .pin_a_o(pin_a_o),
    .pin_a_oe_o(pin_a_oe_o), .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe_o),
    .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o), .overflow_flag_o(overflow_flag_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // run-length ceiling
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk_byte(rdata_o, exp);
  endtask

  // n timer ticks, then one settle edge for the pins
  task automatic tk(input int n);
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    if (n > 0)
      tick_i <= 1'b1;
    repeat (n) @(posedge ref_clk_i);
    tick_i <= 1'b0;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    tick_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    dir_a_i = 1'b1;
    dir_b_i = 1'b1;
    port_a_i = 1'b1;
    port_b_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(addr_control_a, 8'h00);
    rd(addr_control_b, 8'h00);
    chk_bit(overflow_flag_o, 1'b0);
    wr(addr_control_a, 8'hff);
    rd(addr_control_a, 8'hf3);
    wr(addr_control_b, 8'hff);
    rd(addr_control_b, 8'h18);
    wr(addr_control_a, 8'h00);
    wr(addr_control_b, 8'h08);
    wr(addr_compare_a_lo, 8'h02);
    wr(addr_compare_b_lo, 8'h01);
    // clear-on-match, top = compare a = 2
    ea = 1'b0;
    eb = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(addr_control_a, {ca[i], cb[i], 4'h0});
      tk(3);
      ea = (ca[i] == 2'h1) ? ~ea : ca[i][0];
      eb = (cb[i] == 2'h1) ? ~eb : cb[i][0];
      chk_bit(wave_out_a_o, ea);
      chk_bit(wave_out_b_o, eb);
      chk_bit(pin_a_o, ea);
      chk_bit(pin_b_o, eb);
    end
    wr(addr_control_a, 8'h00);
    tk(0);
    chk_bit(pin_a_o, 1'b1);
    chk_bit(pin_b_oe_o, 1'b1);
    @(posedge ref_clk_i);
    dir_a_i <= 1'b0;
    dir_b_i <= 1'b0;
    tk(0);
    chk_bit(pin_a_oe_o, 1'b0);
    chk_bit(pin_b_oe_o, 1'b0);
    @(posedge ref_clk_i);
    dir_a_i <= 1'b1;
    dir_b_i <= 1'b1;
    // normal mode overflow at maximum
    wr(addr_control_b, 8'h00);
    wr(addr_count_lo, 8'hfe);
    wr(addr_count_hi, 8'hff);
    tk(1);
    chk_bit(overflow_flag_o, 1'b0);
    tk(1);
    chk_bit(overflow_flag_o, 1'b1);
    rd(addr_status, 8'h01);
    wr(addr_status, 8'h01);
    rd(addr_status, 8'h00);
    // fast pwm, top = capture = 4
    wr(addr_control_b, 8'h18);
    wr(addr_control_a, 8'h62);
    wr(addr_capture_lo, 8'h04);
    wr(addr_compare_a_lo, 8'h01);
    wr(addr_compare_b_lo, 8'h02);
    wr(addr_count_lo, 8'h00);
    tk(5);
    chk_bit(wave_out_a_o, 1'b1);
    chk_bit(wave_out_b_o, 1'b1);
    chk_bit(overflow_flag_o, 1'b1);
    tk(2);
    chk_bit(wave_out_a_o, 1'b0);
    tk(1);
    chk_bit(wave_out_b_o, 1'b0);
    chk_bit(pin_b_o, 1'b0);
    wr(addr_control_a, 8'h52);
    port_b_i <= 1'b1;
    tk(0);
    chk_bit(pin_b_o, 1'b1);
    wr(addr_control_b, 8'h08);
    wr(addr_control_a, 8'h41);
    tk(0);
    chk_bit(pin_a_o, 1'b1);
    // phase correct, top = capture = 4
    wr(addr_control_b, 8'h10);
    wr(addr_control_a, 8'h82);
    wr(addr_compare_a_lo, 8'h02);
    wr(addr_status, 8'h01);
    wr(addr_count_lo, 8'h00);
    tk(7);
    chk_bit(wave_out_a_o, 1'b1);
    chk_bit(overflow_flag_o, 1'b0);
    tk(2);
    chk_bit(overflow_flag_o, 1'b1);
    tk(2);
    chk_bit(wave_out_a_o, 1'b0);
    // dual-slope compare at top (a) and bottom (b)
    wr(addr_control_a, 8'hb2);
    wr(addr_compare_a_lo, 8'h04);
    wr(addr_compare_b_lo, 8'h00);
    tk(3);
    chk_bit(wave_out_a_o, 1'b1);
    chk_bit(wave_out_b_o, 1'b1);
    wr(addr_control_a, 8'hc2);
    tk(1);
    chk_bit(wave_out_a_o, 1'b0);
    // fast pwm, compare b equal to top
    wr(addr_control_b, 8'h18);
    wr(addr_control_a, 8'h32);
    wr(addr_compare_b_lo, 8'h04);
    wr(addr_count_lo, 8'h03);
    tk(7);
    chk_bit(wave_out_b_o, 1'b0);
    chk_bit(pin_b_o, 1'b0);
    // phase and frequency correct, top = compare a
    wr(addr_control_b, 8'h10);
    wr(addr_control_a, 8'h41);
    wr(addr_compare_a_lo, 8'h02);
    wr(addr_status, 8'h01);
    tk(8);
    chk_bit(overflow_flag_o, 1'b0);
    chk_bit(wave_out_a_o, 1'b1);
    tk(1);
    chk_bit(overflow_flag_o, 1'b1);
    tk(2);
    chk_bit(wave_out_a_o, 1'b0);
    wrap_up();
  end
endmodule // timer16_waveform_mode_control_test
`default_nettype wire
